// ===== hw/mpd_map.svh
// Contract
// - Code with direction bit clear is an input; 0x00 and reserved codes do nothing.
// - Code 0x01 makes the pin a register update strobe.
// - Code 0x02 makes the pin command full power-down.
// - Code 0x03 makes the pin clear the watchdog timer.
// - Code 0x04 makes the pin clear all pending interrupts.
// - Code 0x05 makes the pin reset tuning-word history.
// - Code 0x10 makes the pin force user holdover.
// - Code 0x11 makes the pin force user free-run.
// - Codes 0x12, 0x13, 0x14 reset, increment, decrement phase offset.
// - Codes 0x20 to 0x23 override reference monitors A to D.
// - Codes 0x30 to 0x33 force validation timeout of references A to D.
// - Codes 0x40 to 0x45 enable clock outputs 0 to 5.
// - Code 0x46 enables all six clock outputs together.
// - Code 0x47 issues a soft sync of the clock distribution.
`ifndef MPD_MAP_SVH
`define MPD_MAP_SVH
`define MPD_NPINS       4
`define MPD_DIR_BIT     7
`define MPD_CODE_NONE   7'h00
`define MPD_CODE_UPD    7'h01
`define MPD_CODE_PDN    7'h02
`define MPD_CODE_WDOG   7'h03
`define MPD_CODE_IRQ    7'h04
`define MPD_CODE_HIST   7'h05
`define MPD_CODE_HOLD   7'h10
`define MPD_CODE_FRUN   7'h11
`define MPD_CODE_PRST   7'h12
`define MPD_CODE_PINC   7'h13
`define MPD_CODE_PDEC   7'h14
`define MPD_CODE_MON    5'h08
`define MPD_CODE_VTO    5'h0C
`define MPD_CODE_OEN    4'h8
`define MPD_CODE_OALL   7'h46
`define MPD_CODE_SYNC   7'h47
`define MPD_NOUT        6
`define MPD_CFG_RST     8'h00
`define MPD_OFF_CFG0    8'h00
`define MPD_OFF_SWCTL   8'h10
`define MPD_OFF_PINST   8'h14
`define MPD_OFF_ACTST   8'h18
`define MPD_RESP_OK     2'h0
`define MPD_RESP_ERR    2'h2
`endif

// ===== hw/mpd_pkg.sv
package mpd_pkg;
  // Internal control actions, packed in the same order as the software
  // control register, so that both can be ORed directly.
  typedef struct packed {
    logic       upd;
    logic       pwr_dn;
    logic       wdog_clr;
    logic       irq_clr;
    logic       hist_rst;
    logic       hold;
    logic       frun;
    logic       ph_rst;
    logic       ph_inc;
    logic       ph_dec;
    logic [3:0] mon_ovr;
    logic [3:0] val_to;
    logic [5:0] out_en;
    logic       dist_sync;
  } mpd_act_t;
  typedef logic [7:0] mpd_cfg_t;
endpackage

// ===== hw/mpd_top.sv
`timescale 1ns/1ps
`include "mpd_map.svh"
module mpd_top
  import mpd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  mfp_i,
  output logic [3:0]       pin_direction_select_bit,
  output mpd_act_t         act_o,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int AW = $bits(mpd_act_t);

  mpd_cfg_t         cfg_q [`MPD_NPINS];
  mpd_act_t         sw_q;
  mpd_act_t         act_q;
  mpd_act_t         pin_act;
  mpd_act_t         pin_vec [`MPD_NPINS];
  logic [3:0]       sync1_q;
  logic [3:0]       sync2_q;
  logic             aw_got_q;
  logic             w_got_q;
  logic [7:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             rvalid_q;
  logic [1:0]       rresp_q;
  logic [31:0]      rdata_q;

  // Maps one configuration code to the action it drives while the pin is
  // high. Output-mode and reserved codes map to no action.
  function automatic mpd_act_t decode(input mpd_cfg_t c);
    mpd_act_t a;
    a = '0;
    if (!c[`MPD_DIR_BIT]) begin
      case (c[6:0])
        `MPD_CODE_UPD:  a.upd = 1'b1;
        `MPD_CODE_PDN:  a.pwr_dn = 1'b1;
        `MPD_CODE_WDOG: a.wdog_clr = 1'b1;
        `MPD_CODE_IRQ:  a.irq_clr = 1'b1;
        `MPD_CODE_HIST: a.hist_rst = 1'b1;
        `MPD_CODE_HOLD: a.hold = 1'b1;
        `MPD_CODE_FRUN: a.frun = 1'b1;
        `MPD_CODE_PRST: a.ph_rst = 1'b1;
        `MPD_CODE_PINC: a.ph_inc = 1'b1;
        `MPD_CODE_PDEC: a.ph_dec = 1'b1;
        `MPD_CODE_OALL: a.out_en = '1;
        `MPD_CODE_SYNC: a.dist_sync = 1'b1;
        default: begin
          if (c[6:2] == `MPD_CODE_MON)
            a.mon_ovr[c[1:0]] = 1'b1;
          if (c[6:2] == `MPD_CODE_VTO)
            a.val_to[c[1:0]] = 1'b1;
          if (c[6:3] == `MPD_CODE_OEN && c[2:0] < 3'h6)
            a.out_en[c[2:0]] = 1'b1;
        end
      endcase
    end
    return a;
  endfunction

  // The pins are asynchronous to the core clock.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= mfp_i;
      sync2_q <= sync1_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `MPD_NPINS; gi++) begin : g_pin
      assign pin_vec[gi] = sync2_q[gi] ? decode(cfg_q[gi]) : '0;
      assign pin_direction_select_bit[gi] = cfg_q[gi][`MPD_DIR_BIT];
    end
  endgenerate

  always_comb begin
    pin_act = '0;
    for (int i = 0; i < `MPD_NPINS; i++)
      pin_act = pin_act | pin_vec[i];
  end

  // A software bit and a pin both drive the same action.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      act_q <= '0;
    else
      act_q <= sw_q | pin_act;
  end

  assign act_o = act_q;

  // Write channel: address and data are taken independently, in any order.
  wire aw_hs  = s_axi_awvalid && s_axi_awready;
  wire w_hs   = s_axi_wvalid && s_axi_wready;
  wire wr_go  = aw_got_q && w_got_q && !bvalid_q;
  wire [7:0] wa = awaddr_q;
  wire wa_cfg = (wa[7:4] == 4'h0) && (wa[1:0] == 2'h0);
  wire wa_sw  = (wa == `MPD_OFF_SWCTL);
  wire wa_ro  = (wa == `MPD_OFF_PINST) || (wa == `MPD_OFF_ACTST);

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready  = !w_got_q && !bvalid_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `MPD_NPINS; i++)
        cfg_q[i] <= `MPD_CFG_RST;
    end else if (wr_go && wa_cfg && wstrb_q[0]) begin
      cfg_q[wa[3:2]] <= wdata_q[7:0];
    end
  end

  // Software bits are levels; a pulsed command is issued by writing one
  // and then zero, the same discipline asked of the pin driver.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sw_q <= '0;
    end else if (wr_go && wa_sw) begin
      for (int b = 0; b < 4; b++)
        if (wstrb_q[b])
          for (int k = 0; k < 8; k++)
            if (b * 8 + k < AW)
              sw_q[b * 8 + k] <= wdata_q[b * 8 + k];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `MPD_RESP_OK;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wa_cfg || wa_sw || wa_ro) ? `MPD_RESP_OK
                                              : `MPD_RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Read channel: one read at a time, answered the cycle after it is taken.
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire [7:0] ra = s_axi_araddr;
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `MPD_RESP_OK;
      rdata_q  <= 32'h0000_0000;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `MPD_RESP_OK;
      rdata_q  <= 32'h0000_0000;
      if (ra[7:4] == 4'h0 && ra[1:0] == 2'h0)
        rdata_q[7:0] <= cfg_q[ra[3:2]];
      else if (ra == `MPD_OFF_SWCTL)
        rdata_q[AW-1:0] <= sw_q;
      else if (ra == `MPD_OFF_PINST)
        rdata_q[3:0] <= sync2_q;
      else if (ra == `MPD_OFF_ACTST)
        rdata_q[AW-1:0] <= act_q;
      else
        rresp_q <= `MPD_RESP_ERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sync_two_stage_a: assert property (
    ##2 sync2_q[0] == $past(mfp_i[0], 2))
    else $error("pin level not delayed by two stages");
  sw_or_pin_a: assert property (
    ##1 ((act_q & $past(sw_q)) == $past(sw_q)))
    else $error("software bit lost from action");
  out_mode_idle_a: assert property (
    cfg_q[0][`MPD_DIR_BIT] |-> pin_vec[0] == '0)
    else $error("output-mode pin drives an action");
  reserved_idle_a: assert property (
    (cfg_q[0] == 8'h00 || cfg_q[0] == 8'h48) |-> pin_vec[0] == '0)
    else $error("reserved code drives an action");
  upd_strobe_a: assert property (
    (cfg_q[1] == 8'h01 && sync2_q[1]) |=> act_q.upd)
    else $error("update strobe not passed");
  pwr_down_a: assert property (
    (cfg_q[0] == 8'h02 && sync2_q[0]) |=> act_q.pwr_dn)
    else $error("power-down not passed");
  wdog_clr_a: assert property (
    (cfg_q[0] == 8'h03 && sync2_q[0]) |=> act_q.wdog_clr)
    else $error("watchdog clear not passed");
  irq_clr_a: assert property (
    (cfg_q[0] == 8'h04 && sync2_q[0]) |=> act_q.irq_clr)
    else $error("interrupt clear not passed");
  hist_rst_a: assert property (
    (cfg_q[0] == 8'h05 && sync2_q[0]) |=> act_q.hist_rst)
    else $error("history reset not passed");
  holdover_a: assert property (
    (cfg_q[2] == 8'h10 && sync2_q[2]) |=> act_q.hold)
    else $error("holdover not passed");
  free_run_a: assert property (
    (cfg_q[2] == 8'h11 && sync2_q[2]) |=> act_q.frun)
    else $error("free-run not passed");
  phase_step_a: assert property (
    (cfg_q[3] == 8'h14 && sync2_q[3] && sw_q == '0 &&
     sync2_q[2:0] == 3'h0) |=> act_q == mpd_act_t'(25'h008000))
    else $error("phase decrement wrong");
  mon_ovr_a: assert property (
    (cfg_q[1] == 8'h22 && sync2_q[1]) |=> act_q.mon_ovr[2])
    else $error("monitor override C not passed");
  val_to_a: assert property (
    (cfg_q[1] == 8'h33 && sync2_q[1]) |=> act_q.val_to[3])
    else $error("validation timeout D not passed");
  out_en_a: assert property (
    (cfg_q[0] == 8'h45 && sync2_q[0]) |=> act_q.out_en[5])
    else $error("output 5 enable not passed");
  out_all_a: assert property (
    (cfg_q[0] == 8'h46 && sync2_q[0]) |=> act_q.out_en == 6'h3F)
    else $error("all-output enable not passed");
  dist_sync_a: assert property (
    (cfg_q[3] == 8'h47 && sync2_q[3]) |=> act_q.dist_sync)
    else $error("distribution sync not passed");
  ph_reset_a: assert property (
    (cfg_q[1] == 8'h12 && sync2_q[1]) |=> act_q.ph_rst)
    else $error("phase offset reset not passed");
  ph_inc_a: assert property (
    (cfg_q[2] == 8'h13 && sync2_q[2]) |=> act_q.ph_inc)
    else $error("phase increment not passed");
  mon_ref_a: assert property (
    (cfg_q[3] == 8'h20 && sync2_q[3]) |=> act_q.mon_ovr[0])
    else $error("monitor override A not passed");
  val_ref_a: assert property (
    (cfg_q[2] == 8'h30 && sync2_q[2]) |=> act_q.val_to[0])
    else $error("validation timeout A not passed");
  out_zero_a: assert property (
    (cfg_q[3] == 8'h40 && sync2_q[3]) |=> act_q.out_en[0])
    else $error("output 0 enable not passed");

  // The pin-zero sync, output-mode and reserved-code checks are repeated for
  // every pin, since a wrong index in the pin loop would leave pin zero unharmed.
  generate
    for (gi = 0; gi < `MPD_NPINS; gi++) begin : g_chk
      pin_sync_a: assert property (
        ##2 sync2_q[gi] == $past(mfp_i[gi], 2))
        else $error("pin level not delayed by two stages");
      pin_out_idle_a: assert property (
        cfg_q[gi][`MPD_DIR_BIT] |-> pin_vec[gi] == '0)
        else $error("output-mode pin drives an action");
      pin_gap_idle_a: assert property (
        (cfg_q[gi] inside {[8'h06:8'h0F], [8'h15:8'h1F], [8'h24:8'h2F],
                           [8'h34:8'h3F], [8'h48:8'h7F]})
        |-> pin_vec[gi] == '0)
        else $error("reserved code drives an action");
    end
  endgenerate

  // Bus answers stand until taken, and a busy channel refuses requests.
  b_hold_a: assert property (
    (s_axi_bvalid && !s_axi_bready) |=>
      (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before taken");
  r_hold_a: assert property (
    (s_axi_rvalid && !s_axi_rready) |=>
      (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
    else $error("read answer changed before taken");
  b_answer_a: assert property (
    wr_go |=> s_axi_bvalid)
    else $error("write response not raised");
  r_answer_a: assert property (
    ar_hs |=> s_axi_rvalid)
    else $error("read answer not raised");
  busy_wr_a: assert property (
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write taken while response pending");
  busy_rd_a: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  ro_wr_a: assert property (
    (wr_go && wa_ro) |=> $stable(sw_q))
    else $error("status write changed control bits");
  rd_hi_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:AW] == '0)
    else $error("unused read bits not zero");

  pin_pwr_c:  cover property (cfg_q[0] == 8'h02 && sync2_q[0]);
  pin_all_c:  cover property (act_q.out_en == 6'h3F);
  sw_wr_c:    cover property (wr_go && wa_sw);
  cfg_wr_c:   cover property (wr_go && wa_cfg);
  bad_rd_c:   cover property (s_axi_rvalid && rresp_q == `MPD_RESP_ERR);

endmodule

// ===== bench/mpd_pins_model.sv
`timescale 1ns/1ps
// Board logic that drives the multifunction pins. A requested level is
// only taken over once the present level has stood for two edges, so a
// short pulse from the bench can never slip past the synchronizer.
module mpd_pins_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] want_lvl,
  output logic      [3:0] mfp_o
);
  logic [1:0] held_q;

  initial begin
    mfp_o  = 4'h0;
    held_q = 2'h0;
  end

  always @(posedge core_clk) begin
    if (want_lvl != mfp_o && held_q != 2'h0) begin
      mfp_o  <= want_lvl;
      held_q <= 2'h0;
    end else if (held_q != 2'h3) begin
      held_q <= held_q + 2'h1;
    end
  end
endmodule

// ===== bench/mpd_top_tb.sv
`timescale 1ns/1ps
module mpd_top_tb;
  import mpd_pkg::*;
  logic        core_clk, rstn, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0]  want_lvl, mfp, dir, wstrb;
  logic [7:0]  awaddr, araddr, c;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  mpd_act_t    act;
  int          err_total, samples_checked, i, p;

  mpd_pins_model pins_u (.core_clk(core_clk), .want_lvl(want_lvl),
    .mfp_o(mfp));
  mpd_top dut_u (.core_clk(core_clk), .rstn(rstn), .mfp_i(mfp),
    .pin_direction_select_bit(dir), .act_o(act),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // The expected action is worked out per code, independent of the design.
  function automatic logic [31:0] exp_act(input logic [7:0] cd);
    case (cd)
      8'h01, 8'h02, 8'h03: return 32'h1 << (8'd25 - cd);
      8'h04, 8'h05: return 32'h1 << (8'd25 - cd);
      8'h10, 8'h11: return 32'h1 << (8'd35 - cd);
      8'h12, 8'h13, 8'h14: return 32'h1 << (8'd35 - cd);
      8'h20, 8'h21, 8'h22, 8'h23: return 32'h800 << (cd - 8'h20);
      8'h30, 8'h31, 8'h32, 8'h33: return 32'h80 << (cd - 8'h30);
      8'h40, 8'h41, 8'h42: return 32'h2 << (cd - 8'h40);
      8'h43, 8'h44, 8'h45: return 32'h2 << (cd - 8'h40);
      8'h46: return 32'h7E;
      8'h47: return 32'h1;
      default: return 32'h0;
    endcase
  endfunction

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int n;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      err_total++;
      test_done();
    end else begin
      chk("bresp", {30'h0, bresp}, {30'h0, er});
      // One idle edge keeps the next call from raising bready again in
      // the same step in which this one lowered it.
      @(posedge core_clk);
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    if (rvalid !== 1'b1) begin
      err_total++;
      test_done();
    end else begin
      d = rdata;
      r = rresp;
      @(posedge core_clk);
    end
  endtask

  initial begin
    {rstn, want_lvl, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    err_total = 0;
    samples_checked = 0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk("act_rst", 32'(act), 32'h0);
    chk("dir_rst", {28'h0, dir}, 32'h0);
    for (i = 0; i < 5; i++) begin
      axr(8'(i * 4), rd, rs);
      chk("reg_rst", rd, 32'h0);
    end
    $display("test reset done");
    // Every code on every pin in turn; idle pins stay low.
    for (i = 0; i < 1024; i++) begin
      c = 8'(i / 4);
      p = i % 4;
      axw(8'(p * 4), {24'h0, c}, 2'h0);
      chk("dir_bit", {31'h0, dir[p]}, {31'h0, c[7]});
      want_lvl[p] <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("act_high", 32'(act), exp_act(c));
      want_lvl[p] <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk("act_low", 32'(act), 32'h0);
    end
    $display("test codes done");
    axw(8'h10, 32'h0080_0000, 2'h0);
    repeat (2) @(posedge core_clk);
    chk("act_sw", 32'(act), 32'h0080_0000);
    axw(8'h04, 32'h47, 2'h0);
    want_lvl[1] <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("act_or", 32'(act), 32'h0080_0001);
    axr(8'h18, rd, rs);
    chk("act_stat", rd, 32'h0080_0001);
    axr(8'h14, rd, rs);
    chk("pin_stat", rd, 32'h2);
    axw(8'h14, 32'hF, 2'h0);
    axr(8'h14, rd, rs);
    chk("pin_stat_ro", rd, 32'h2);
    want_lvl[1] <= 1'b0;
    axw(8'h10, 32'h0, 2'h0);
    repeat (6) @(posedge core_clk);
    chk("act_clr", 32'(act), 32'h0);
    $display("test or done");
    axw(8'h40, 32'h1, 2'h2);
    axr(8'h40, rd, rs);
    chk("unmap_resp", {30'h0, rs}, 32'h2);
    chk("unmap_data", rd, 32'h0);
    $display("test unmapped done");
    // With byte lane 0 off, a config write must leave the code alone.
    wstrb <= 4'hE;
    axw(8'h00, 32'h0000_0002, 2'h0);
    wstrb <= 4'hF;
    axr(8'h00, rd, rs);
    chk("strb_cfg", rd, 32'hFF);
    $display("test strobe done");
    test_done();
  end
endmodule
